// >>> logic/lpc_pkg.sv
// Purpose: constants and carriers for the low-power memory clock/CKE sequencer
// Assumes: one command slot per link clock cycle
// Notes:   cycle counts derive from times at the 40 MHz rate
package lpc_pkg;
  localparam int unsigned CLK_PERIOD_PS = 25000;
  localparam int unsigned T_DQSCK_MAX_PS = 5500;
  localparam int unsigned T_WR_PS = 15000;
  localparam int unsigned T_IHCKE_PS = 250;
  localparam int unsigned T_ISCKE_PS = 250;
  localparam int unsigned T_MRW_CK = 5;
  localparam int unsigned T_XP_PS = 7500;
  localparam int unsigned T_CKE_CK = 3;
  function automatic int unsigned ru(input int unsigned t);
    return (t + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  endfunction
  function automatic int unsigned atLeastOne(input int unsigned c);
    return (c < 1) ? 1 : c;
  endfunction
  localparam int unsigned DQSCK_CYC = atLeastOne(ru(T_DQSCK_MAX_PS));
  localparam int unsigned WR_CYC = atLeastOne(ru(T_WR_PS));
  localparam int unsigned IHCKE_CYC = atLeastOne(ru(T_IHCKE_PS));
  localparam int unsigned ISCKE_CYC = atLeastOne(ru(T_ISCKE_PS));
  localparam int unsigned XP_CYC = atLeastOne(ru(T_XP_PS));
  localparam int unsigned STABLE_CLKS = 2;
  localparam int unsigned CKWIDTH = 8;
  localparam logic [2:0] CA_DPD = 3'h3;
  localparam logic [2:0] CA_NOP = 3'h7;
  localparam logic [2:0] CA_REFAB = 3'h4;
  localparam logic [2:0] CA_MRW = 3'h0;
  localparam logic [2:0] CA_READ = 3'h5;
  localparam logic [2:0] CA_WRITE = 3'h1;
  typedef enum logic [2:0] {
    CMD_NONE, CMD_READ, CMD_WRITE, CMD_REFRESH, CMD_MRW, CMD_OTHER
  } lpc_cmd_t;
  typedef struct packed {
    logic cke;
    logic csB;
    logic [2:0] ca;
    logic ckT;
    logic ckC;
  } lpc_pins_t;
  typedef struct packed {
    logic [7:0] rl;
    logic [7:0] wl;
    logic [7:0] bl;
  } lpc_cfg_t;
endpackage : lpc_pkg

// >>> logic/lpc_ctrl.sv
// Purpose: controller side sequencing of power-down, deep power-down and clock stop
// Assumes: user issues one request at a time; init sequence run by caller
// Notes:   cmdReady is combinational; pins come from flops
//
// Notes on behaviour
// - read to power-down waits RL+RU(dqsck)+BL/2+1
// - write to power-down waits WL+1+BL/2+RU(tWR)
// - refresh to power-down waits tIHCKE
// - mode write to power-down waits tMRW
// - NOP follows deep power-down entry
// - CKE stays high during mode accesses
// - DPD exit: CKE high, tISCKE, stable clock
// - full initialization after deep power-down exit
// - clock change only with banks settled
// - keep clock two cycles after CKE falls
// - two good clocks before CKE rises
// - each clock period within limits
// - stopped clock parks true low, complement high
// - CKE-high clock change needs CS high, idle
// - reprogram latencies after frequency change
// - NOP needs CKE level unchanged
// - illegal event forces power-down and re-init
// - power-down exit with CS high, wait tXP
`timescale 1ns/10ps
module lpc_ctrl #(
  parameter int unsigned CKDIV = 2
) (
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire lpc_pkg::lpc_cmd_t cmdIn,
  input  wire logic              cmdValid,
  output logic                   cmdReady,
  input  wire lpc_pkg::lpc_cfg_t cfg,
  input  wire logic              pdReq,
  input  wire logic              dpdReq,
  input  wire logic              clkStopReq,
  input  wire logic              wakeReq,
  input  wire logic              illegalEvt,
  input  wire logic              banksSettled,
  output logic                   needInit,
  output logic                   linkReady,
  output lpc_pkg::lpc_pins_t     pins
);
  typedef enum logic [2:0] {S_RUN, S_PD, S_DPD, S_STOP, S_WAKE} lpc_state_t;
  // system clocks per link clock period, and the run-in before cke may rise
  localparam int unsigned LINK_SYS = 2 * CKDIV;
  localparam int unsigned RUN_MIN  = lpc_pkg::STABLE_CLKS * LINK_SYS;
  lpc_state_t state_ff;
  logic [lpc_pkg::CKWIDTH-1:0] runCnt_ff;
  logic                        linkTick;
  logic [lpc_pkg::CKWIDTH-1:0] gate_ff;
  logic [lpc_pkg::CKWIDTH-1:0] lowCnt_ff;
  logic [lpc_pkg::CKWIDTH-1:0] wakeCnt_ff;
  logic [lpc_pkg::CKWIDTH-1:0] divCnt_ff;
  logic ckRun_ff, ckPh_ff, lastDpd_ff, needInit_ff;
  logic [lpc_pkg::CKWIDTH-1:0] nxt_gate;
  logic issue, enterPd, enterDpd, stopOk, mrwBusy;

  // entry delay computed from live latency settings
  always_comb begin
    nxt_gate = (gate_ff != '0) ? gate_ff - 8'h01 : '0;
    if (issue) begin
      unique case (cmdIn)
        // gaps are link cycles, counted here in system clocks
        lpc_pkg::CMD_READ: nxt_gate = 8'((int'(cfg.rl) + lpc_pkg::DQSCK_CYC
                                          + int'(cfg.bl >> 1) + 1) * LINK_SYS);
        lpc_pkg::CMD_WRITE: nxt_gate = 8'((int'(cfg.wl) + 1 + int'(cfg.bl >> 1)
                                           + lpc_pkg::WR_CYC) * LINK_SYS);
        lpc_pkg::CMD_REFRESH: nxt_gate = 8'(lpc_pkg::IHCKE_CYC * LINK_SYS);
        lpc_pkg::CMD_MRW: nxt_gate = 8'(lpc_pkg::T_MRW_CK * LINK_SYS);
        default: nxt_gate = (gate_ff != '0) ? gate_ff - 8'h01 : '0;
      endcase
    end
  end

  assign mrwBusy = (gate_ff != '0);
  // pins change only one system clock before a link rise, so each stands a whole link cycle
  assign linkTick = ckRun_ff && !ckPh_ff && (divCnt_ff == 8'(CKDIV - 1));
  assign cmdReady = (state_ff == S_RUN) && linkReady && linkTick && !needInit_ff;
  assign issue = cmdValid && cmdReady;
  assign enterPd = (state_ff == S_RUN) && linkTick && !issue && !mrwBusy
                   && (pdReq || clkStopReq);
  assign enterDpd = (state_ff == S_RUN) && linkTick && !issue && !mrwBusy && dpdReq;
  assign stopOk = banksSettled && (lowCnt_ff >= 8'(RUN_MIN));

  // system clocks run since the last restart, saturating
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) runCnt_ff <= '0;
    else if (!ckRun_ff) runCnt_ff <= '0;
    else if (runCnt_ff != '1) runCnt_ff <= runCnt_ff + 8'h01;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) gate_ff <= '0;
    else gate_ff <= nxt_gate;
  end

  // cycles since CKE fell, saturating
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) lowCnt_ff <= '0;
    else if (state_ff == S_RUN || state_ff == S_WAKE) lowCnt_ff <= '0;
    else if (lowCnt_ff != '1) lowCnt_ff <= lowCnt_ff + 8'h01;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) state_ff <= S_RUN;
    else begin
      unique case (state_ff)
        S_RUN: begin
          if (illegalEvt && linkTick) state_ff <= S_DPD;
          else if (enterDpd) state_ff <= S_DPD;
          else if (enterPd) state_ff <= clkStopReq ? S_STOP : S_PD;
        end
        S_PD: if (wakeReq && runCnt_ff >= 8'(RUN_MIN)) state_ff <= S_WAKE;
        S_STOP: if (wakeReq && !ckRun_ff) state_ff <= S_PD;
        S_DPD: if (wakeReq) state_ff <= S_WAKE;
        S_WAKE: if (wakeCnt_ff == '0) state_ff <= S_RUN;
      endcase
    end
  end

  // clock runs except in stop after two cycles restart ahead of CKE
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) ckRun_ff <= 1'b1;
    else if (state_ff == S_STOP && stopOk && !wakeReq) ckRun_ff <= 1'b0;
    else if (wakeReq) ckRun_ff <= 1'b1;
  end

  // fixed divider keeps every period equal park true low
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      divCnt_ff <= '0;
      ckPh_ff <= 1'b0;
    end else if (!ckRun_ff) begin
      divCnt_ff <= '0;
      ckPh_ff <= 1'b0;
    end else if (divCnt_ff == 8'(CKDIV - 1)) begin
      divCnt_ff <= '0;
      ckPh_ff <= !ckPh_ff;
    end else divCnt_ff <= divCnt_ff + 8'h01;
  end

  // wake hold covers two clocks plus tXP, tISCKE and tCKE
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) wakeCnt_ff <= '0;
    else if (state_ff != S_WAKE) wakeCnt_ff <= 8'((lpc_pkg::STABLE_CLKS * 2 * CKDIV)
                                  + lpc_pkg::XP_CYC + lpc_pkg::ISCKE_CYC + lpc_pkg::T_CKE_CK);
    else if (wakeCnt_ff != '0) wakeCnt_ff <= wakeCnt_ff - 8'h01;
  end

  // after DPD the caller must re-init; contents treated lost
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) needInit_ff <= 1'b0;
    else if (state_ff == S_DPD) needInit_ff <= 1'b1;
    else if (issue && cmdIn == lpc_pkg::CMD_MRW) needInit_ff <= 1'b0;
  end
  assign needInit = needInit_ff;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) lastDpd_ff <= 1'b0;
    else if (linkTick) lastDpd_ff <= enterDpd || (state_ff == S_RUN && illegalEvt);
  end

  assign linkReady = ckRun_ff && (state_ff == S_RUN);

  // pin drive; NOP uses CS high whenever CKE steady
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) pins <= '{cke: 1'b1, csB: 1'b1, ca: lpc_pkg::CA_NOP, ckT: 1'b0, ckC: 1'b1};
    else begin
      pins.ckT <= ckRun_ff ? ckPh_ff : 1'b0;
      pins.ckC <= ckRun_ff ? !ckPh_ff : 1'b1;
      if (linkTick) begin
        pins.csB <= 1'b1;
        pins.ca <= lpc_pkg::CA_NOP;
        if (state_ff == S_RUN && (enterDpd || illegalEvt)) begin
          pins.cke <= 1'b0;
          pins.csB <= 1'b0;
          pins.ca <= lpc_pkg::CA_DPD;
        end else if (enterPd) pins.cke <= 1'b0;
        else if (state_ff == S_WAKE || state_ff == S_RUN) pins.cke <= 1'b1;
        else if (lastDpd_ff) pins.cke <= 1'b0;
        if (issue) begin
          pins.csB <= 1'b0;
          unique case (cmdIn)
            lpc_pkg::CMD_READ: pins.ca <= lpc_pkg::CA_READ;
            lpc_pkg::CMD_WRITE: pins.ca <= lpc_pkg::CA_WRITE;
            lpc_pkg::CMD_REFRESH: pins.ca <= lpc_pkg::CA_REFAB;
            lpc_pkg::CMD_MRW: pins.ca <= lpc_pkg::CA_MRW;
            default: pins.csB <= 1'b1;
          endcase
        end
      end
    end
  end

  a_pd_gap: assert property (@(posedge clock) disable iff (!rst_b)
    (issue && cmdIn == lpc_pkg::CMD_READ) |=> !enterPd [*2]) else $error("early pd after read");
  a_mrw_cke: assert property (@(posedge clock) disable iff (!rst_b)
    (issue && cmdIn == lpc_pkg::CMD_MRW) |=> pins.cke [*4]) else $error("cke low in mrw");
  a_dpd_nop: assert property (@(posedge clock) disable iff (!rst_b)
    (linkTick && !pins.csB && pins.ca == lpc_pkg::CA_DPD) |=> pins.csB)
    else $error("no nop after dpd");
  a_park_clk: assert property (@(posedge clock) disable iff (!rst_b)
    !ckRun_ff |=> (!pins.ckT && pins.ckC)) else $error("clock not parked");
  a_stop_hold: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(pins.cke) |-> ckRun_ff [*2]) else $error("clock stopped early");
  a_wake_clk: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(pins.cke) |-> (runCnt_ff >= 8'(RUN_MIN))) else $error("cke rose without clock");
  a_stop_late: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(ckRun_ff) |-> (lowCnt_ff >= 8'(RUN_MIN))) else $error("clock stopped too soon");
  a_pd_cs: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(pins.cke) |-> pins.csB) else $error("exit with cs low");
  a_init_dpd: assert property (@(posedge clock) disable iff (!rst_b)
    (state_ff == S_DPD) |=> needInit_ff) else $error("init flag missing");
endmodule : lpc_ctrl

// >>> tb/lpc_dev_model.sv
// Purpose: behavioural memory device seen from the pin side
// Assumes: commands registered on rising edges of the true clock line
// Notes:   counts protocol slips in errs; no array data is held
`timescale 1ns/10ps
module lpc_dev_model (
  input  wire lpc_pkg::lpc_pins_t pins,
  output int                      errs,
  output logic                    inDpd,
  output logic                    inPd,
  output logic                    dataValid
);
  logic prevCke;
  logic justDpd;
  int   burstLeft;
  initial begin
    errs = 0; inDpd = 1'b0; inPd = 1'b0; dataValid = 1'b1;
    prevCke = 1'b1; justDpd = 1'b0; burstLeft = 0;
  end
  function automatic logic isNop(input lpc_pkg::lpc_pins_t p);
    return p.csB || (p.ca == lpc_pkg::CA_NOP);
  endfunction
  always @(posedge pins.ckT) begin
    if (burstLeft > 0) burstLeft <= burstLeft - 1; // nop never cuts it short
    if (justDpd && !isNop(pins)) errs <= errs + 1;
    justDpd <= 1'b0;
    if (inDpd) begin
      if (pins.cke) inDpd <= 1'b0; // only cke is heard while off
    end else if (prevCke && !pins.cke) begin
      if (!pins.csB && pins.ca == lpc_pkg::CA_DPD) begin
        inDpd     <= 1'b1;
        dataValid <= 1'b0; // array contents gone
        justDpd   <= 1'b1;
      end else if (pins.csB) inPd <= 1'b1;
      else errs <= errs + 1;
    end else if (!prevCke && pins.cke) begin
      inPd <= 1'b0;
      if (!pins.csB) errs <= errs + 1;
    end else if (pins.cke && !pins.csB && pins.ca == lpc_pkg::CA_READ) burstLeft <= 4;
    prevCke <= pins.cke;
  end
endmodule // lpc_dev_model

// >>> tb/lpddr2_power_down_clock_control_bench.sv
// Purpose: self-checking bench for the power-down and clock-stop sequencer
// Assumes: CKDIV left at 2; gaps measured in system clocks, a lower bound
// Notes:   deep power-down runs last of a reset span since only reset clears it
`timescale 1ns/10ps
module lpddr2_power_down_clock_control_bench;
  logic clock = 1'b0, rst_b = 1'b0, cmdValid = 1'b0, pdReq = 1'b0, dpdReq = 1'b0;
  logic clkStopReq = 1'b0, wakeReq = 1'b0, illegalEvt = 1'b0, banksSettled = 1'b1;
  logic cmdReady, needInit, linkReady, inDpd, inPd, dataValid;
  lpc_pkg::lpc_cmd_t  cmdIn = lpc_pkg::CMD_NONE;
  lpc_pkg::lpc_cfg_t  cfg = '{rl: 8'h08, wl: 8'h04, bl: 8'h08};
  lpc_pkg::lpc_pins_t pins;
  int n_fail = 0, n_checks = 0, errs, n;
  lpc_ctrl lpc_ctrl_inst (.clock(clock), .rst_b(rst_b), .cmdIn(cmdIn), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cfg(cfg), .pdReq(pdReq), .dpdReq(dpdReq), .clkStopReq(clkStopReq),
    .wakeReq(wakeReq), .illegalEvt(illegalEvt), .banksSettled(banksSettled),
    .needInit(needInit), .linkReady(linkReady), .pins(pins));
  lpc_dev_model lpc_dev_model_inst (.pins(pins), .errs(errs), .inDpd(inDpd), .inPd(inPd),
    .dataValid(dataValid));
  initial forever #12.5 clock = ~clock;
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic doReset();
    rst_b = 1'b0;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
  endtask
  // bounded wait until cke reaches lvl; n holds the cycles spent
  task automatic waitCke(input logic lvl);
    n = 0;
    while (pins.cke !== lvl && n < 600) begin
      @(negedge clock);
      n++;
    end
  endtask
  task automatic issue(input lpc_pkg::lpc_cmd_t c);
    @(posedge clock);
    cmdIn <= c;
    cmdValid <= 1'b1;
    n = 0;
    do begin @(negedge clock); n++; end while (cmdReady !== 1'b1 && n < 200);
    @(posedge clock);
    cmdValid <= 1'b0;
  endtask
  task automatic wake();
    @(posedge clock);
    pdReq <= 1'b0; clkStopReq <= 1'b0; wakeReq <= 1'b1;
    waitCke(1'b1);
    chk("csB at exit", pins.csB, 1'b1);
    n = 0;
    while (linkReady !== 1'b1 && n < 400) begin @(negedge clock); n++; end
    chk("ready after exit", linkReady, 1'b1);
    @(posedge clock);
    wakeReq <= 1'b0;
  endtask
  // command then power-down request; cke must not fall before minGap
  task automatic entryGap(input lpc_pkg::lpc_cmd_t c, input int minGap);
    issue(c);
    pdReq <= 1'b1;
    waitCke(1'b0);
    chk("gap long enough", n >= minGap * 4, 1'b1);
    @(posedge pins.ckT);
    @(negedge clock);
    chk("pd entered", inPd, 1'b1);
    wake();
  endtask
  task automatic clkStop();
    @(posedge clock);
    pdReq <= 1'b1;
    clkStopReq <= 1'b1;
    waitCke(1'b0);
    repeat (40) @(negedge clock);
    repeat (8) begin
      @(negedge clock);
      chk("parked ckT", pins.ckT, 1'b0);
      chk("parked ckC", pins.ckC, 1'b1);
    end
    wake();
  endtask
  task automatic deepDown();
    @(posedge clock);
    dpdReq <= 1'b1;
    waitCke(1'b0);
    chk("dpd csB", pins.csB, 1'b0);
    chk("dpd ca", pins.ca, lpc_pkg::CA_DPD);
    @(posedge pins.ckT);
    repeat (4) @(negedge clock);
    chk("nop after dpd", pins.csB | (pins.ca == lpc_pkg::CA_NOP), 1'b1);
    dpdReq <= 1'b0;
    repeat (4) @(negedge clock);
    chk("init needed", needInit, 1'b1);
    chk("refused", cmdReady, 1'b0);
    chk("array lost", dataValid, 1'b0);
  endtask
  initial begin
    #2_000_000;
    n_fail++;
    end_of_test();
  end
  initial begin
    doReset();
    @(negedge clock);
    chk("reset pins", pins, {1'b1, 1'b1, 3'h7, 1'b0, 1'b1});
    entryGap(lpc_pkg::CMD_READ, 8 + lpc_pkg::DQSCK_CYC + 4 + 1);
    entryGap(lpc_pkg::CMD_WRITE, 4 + 1 + 4 + lpc_pkg::WR_CYC);
    entryGap(lpc_pkg::CMD_REFRESH, lpc_pkg::IHCKE_CYC);
    entryGap(lpc_pkg::CMD_MRW, lpc_pkg::T_MRW_CK);
    clkStop();
    deepDown();
    doReset();
    @(posedge clock);
    illegalEvt <= 1'b1;
    waitCke(1'b0);
    illegalEvt <= 1'b0;
    chk("illegal powers down", pins.cke, 1'b0);
    repeat (4) @(negedge clock);
    chk("illegal needs init", needInit, 1'b1);
    chk("model slips", errs, 0);
    end_of_test();
  end
endmodule // lpddr2_power_down_clock_control_bench
